// File: programmable_stage.sv
// programmable protection stage: comparators, timing, events, counters, log
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "ps_map.svh"
module programmable_stage #(
	parameter int TICK_CYCLES = `PROG_CYCLE_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	// register port
	input wire ps_pkg::reg_req_s REG_REQ_I,
	output logic [31:0] REG_RDATA_O,
	// measurement and system inputs
	input wire logic [2:0][31:0] MEAS_I,
	input wire logic BLOCK_I,
	input wire logic [2:0] SET_GROUP_I,
	input wire logic [31:0] TIME_I,
	// stage outputs
	output logic START_O,
	output logic TRIP_O,
	output logic BLOCKED_O,
	output ps_pkg::evt_s EVT_O
);
	localparam int TAPS = `DELTA_TAPS;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic ps_pkg::wide_t sx(input logic [31:0] v);
		sx = {{32{v[31]}}, v};
	endfunction : sx
	function automatic ps_pkg::wide_t absw(input ps_pkg::wide_t v);
		absw = v[63] ? -v : v;
	endfunction : absw
	// ratio clipped to the display range; zero pick-up gives zero
	function automatic logic [31:0] ratio_of(input logic [31:0] m, input logic [31:0] p);
		ps_pkg::wide_t q;
		q = 64'sd0;
		if (p != 32'h0) q = sx(m) / sx(p);
		if (q > `RATIO_LIM) q = `RATIO_LIM;
		if (q < -`RATIO_LIM) q = -`RATIO_LIM;
		return q[31:0];
	endfunction : ratio_of
	// ---------------------------------------------------------------
	// program cycle tick
	// ---------------------------------------------------------------
	logic [19:0] tick_cnt_q;
	wire tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I || tick) tick_cnt_q <= 20'h0;
		else tick_cnt_q <= tick_cnt_q + 20'h1;
	end
	// ---------------------------------------------------------------
	// register write decode
	// ---------------------------------------------------------------
	wire [7:0] addr = REG_REQ_I.addr;
	wire [31:0] wdat = REG_REQ_I.wdata;
	wire wr = REG_REQ_I.wr;
	wire ch_hit = (addr <= `A_CH_LAST);
	wire [1:0] ch_idx = 2'(addr >> `CH_SHIFT);
	wire [7:0] fld = addr & `FLD_MASK;
	wire cnt_clr = wr && addr == `A_CTRL && wdat[0];
	logic [3:0] mode_q [`N_CH];
	logic [31:0] pick_q [`N_CH];
	logic [15:0] hyst_q [`N_CH];
	logic [31:0] blim_q [`N_CH];
	logic [18:0] opdly_q, reldly_q;
	logic [5:0] evmask_q;
	logic [3:0] log_sel_q;
	// per-level settings, each pick-up signed
	always_ff @(posedge CORE_CLK_I) begin
		for (int i = 0; i < `N_CH; i++) begin
			if (RESET_I) begin
				mode_q[i] <= `MODE_RST;
				pick_q[i] <= `PICK_RST;
				hyst_q[i] <= `HYST_RST;
				blim_q[i] <= `BLIM_RST;
			end else if (wr && ch_hit && ch_idx == 2'(i)) begin
				if (fld == `F_MODE) mode_q[i] <= wdat[3:0];
				if (fld == `F_PICK) pick_q[i] <= wdat;
				if (fld == `F_HYST) hyst_q[i] <= wdat[15:0];
				if (fld == `F_BLIM) blim_q[i] <= wdat;
			end
		end
	end
	// stage settings; delays count 5 ms program cycles
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			opdly_q <= `OPDLY_RST;
			reldly_q <= `RELDLY_RST;
			evmask_q <= `EVMASK_RST;
			log_sel_q <= 4'h0;
		end else if (wr) begin
			if (addr == `A_OPDLY) opdly_q <= wdat[18:0];
			if (addr == `A_RELDLY) reldly_q <= wdat[18:0];
			if (addr == `A_EVMASK) evmask_q <= wdat[5:0];
			if (addr == `A_LOG_SEL) log_sel_q <= wdat[3:0];
		end
	end
	// ---------------------------------------------------------------
	// comparators
	// ---------------------------------------------------------------
	logic [31:0] hist_q [`N_CH][TAPS];
	logic [31:0] ratio_q [`N_CH];
	logic [`N_CH-1:0] act_q;
	logic [`N_CH-1:0] act_d;
	for (genvar g = 0; g < `N_CH; g++) begin : g_ch
		wire ps_pkg::cmp_mode_e md = ps_pkg::cmp_mode_e'(mode_q[g][2:0]);
		wire ps_pkg::wide_t m = sx(MEAS_I[g]);
		wire ps_pkg::wide_t p = sx(pick_q[g]);
		wire ps_pkg::wide_t old = sx(hist_q[g][TAPS-1]);
		// release band is relative to the pick-up magnitude
		wire ps_pkg::wide_t hy = absw(p) * sx({16'h0, hyst_q[g]}) / `PCT_SCALE;
		wire abs_md = (md == ps_pkg::M_OVER_ABS) || (md == ps_pkg::M_UNDER_ABS);
		wire ps_pkg::wide_t x = abs_md ? absw(m) : m;
		wire ps_pkg::wide_t d = m - old;
		wire ps_pkg::wide_t r = d * `PCT_SCALE;
		wire ps_pkg::wide_t t = absw(old) * p;
		wire over_set = x > p;
		wire over_hold = x > p - hy;
		wire under_set = x < p;
		wire under_hold = x < p + hy;
		wire gate = x >= sx(blim_q[g]);
		wire drel_dir = p[63] ? (r < t) : (r > t);
		wire drel_abs = absw(r) > absw(t);
		wire dval_dir = p[63] ? (d < p) : (d > p);
		wire dval_abs = absw(d) > absw(p);
		logic hit;
		always_comb begin
			case (md)
				ps_pkg::M_OVER, ps_pkg::M_OVER_ABS: hit = act_q[g] ? over_hold : over_set;
				ps_pkg::M_UNDER, ps_pkg::M_UNDER_ABS: hit = (act_q[g] ? under_hold : under_set) && gate;
				ps_pkg::M_DREL_DIR: hit = drel_dir;
				ps_pkg::M_DREL_ABS: hit = drel_abs;
				ps_pkg::M_DVAL_DIR: hit = dval_dir;
				ps_pkg::M_DVAL_ABS: hit = dval_abs;
				default: hit = 1'b0;
			endcase
		end
		assign act_d[g] = mode_q[g][`EN_BIT] && hit;
		// history spans 20 ms, one slot per program cycle
		always_ff @(posedge CORE_CLK_I) begin
			if (RESET_I) begin
				for (int k = 0; k < TAPS; k++) hist_q[g][k] <= 32'h0;
				ratio_q[g] <= 32'h0;
			end else begin
				ratio_q[g] <= ratio_of(MEAS_I[g], pick_q[g]);
				if (tick) begin
					hist_q[g][0] <= MEAS_I[g];
					for (int k = 1; k < TAPS; k++) hist_q[g][k] <= hist_q[g][k-1];
				end
			end
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) act_q <= '0;
		else if (tick) act_q <= act_d;
	end
	chk_over_pickup: assert property (tick && mode_q[0] == {1'b1, ps_pkg::M_OVER} && !act_q[0]
		&& $signed(MEAS_I[0]) > $signed(pick_q[0]) |=> act_q[0])
		else $error("over comparison did not pick up");
	chk_under_gate: assert property (tick && mode_q[0] == {1'b1, ps_pkg::M_UNDER}
		&& $signed(MEAS_I[0]) < $signed(blim_q[0]) |=> !act_q[0])
		else $error("under comparison active below blocking limit");
	// ---------------------------------------------------------------
	// stage timing
	// ---------------------------------------------------------------
	ps_pkg::stage_state_e state_q, state_d;
	logic [18:0] opcnt_q, opcnt_d, relcnt_q, relcnt_d;
	wire pick = |act_d;
	wire op_done = (opcnt_q + 19'h1) >= opdly_q;
	wire rel_done = (relcnt_q + 19'h1) >= reldly_q;
	// blocking is only looked at on the program cycle tick
	always_comb begin
		state_d = state_q;
		opcnt_d = opcnt_q;
		relcnt_d = relcnt_q;
		if (tick) begin
			case (state_q)
				ps_pkg::S_IDLE: begin
					opcnt_d = 19'h0;
					if (pick && BLOCK_I) state_d = ps_pkg::S_BLOCKED;
					else if (pick) state_d = ps_pkg::S_START;
				end
				ps_pkg::S_START, ps_pkg::S_TRIP: begin
					relcnt_d = 19'h0;
					if (BLOCK_I) state_d = pick ? ps_pkg::S_BLOCKED : ps_pkg::S_IDLE;
					else if (!pick) state_d = (state_q == ps_pkg::S_START) ? ps_pkg::S_REL_S : ps_pkg::S_REL_T;
					else if (state_q == ps_pkg::S_START) begin
						opcnt_d = opcnt_q + 19'h1;
						if (op_done) state_d = ps_pkg::S_TRIP;
					end
				end
				ps_pkg::S_REL_S, ps_pkg::S_REL_T: begin
					relcnt_d = relcnt_q + 19'h1;
					if (BLOCK_I) state_d = pick ? ps_pkg::S_BLOCKED : ps_pkg::S_IDLE;
					else if (pick) state_d = (state_q == ps_pkg::S_REL_S) ? ps_pkg::S_START : ps_pkg::S_TRIP;
					else if (rel_done) state_d = ps_pkg::S_IDLE;
				end
				ps_pkg::S_BLOCKED: begin
					opcnt_d = 19'h0;
					if (!pick || !BLOCK_I) state_d = ps_pkg::S_IDLE;
				end
				default: state_d = ps_pkg::S_IDLE;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			state_q <= ps_pkg::S_IDLE;
			opcnt_q <= 19'h0;
			relcnt_q <= 19'h0;
		end else begin
			state_q <= state_d;
			opcnt_q <= opcnt_d;
			relcnt_q <= relcnt_d;
		end
	end
	// outputs stay up through the release delay
	assign START_O = (state_q != ps_pkg::S_IDLE) && (state_q != ps_pkg::S_BLOCKED);
	assign TRIP_O = (state_q == ps_pkg::S_TRIP) || (state_q == ps_pkg::S_REL_T);
	assign BLOCKED_O = (state_q == ps_pkg::S_BLOCKED);
	wire [18:0] remain = (opcnt_q < opdly_q) ? opdly_q - opcnt_q : 19'h0;
	sequence s_idle_pick;
		tick && state_q == ps_pkg::S_IDLE && pick;
	endsequence
	chk_start_raise: assert property (s_idle_pick ##0 !BLOCK_I |=> START_O && !BLOCKED_O)
		else $error("start not raised on unblocked pick-up");
	chk_blocked_raise: assert property (s_idle_pick ##0 BLOCK_I |=> BLOCKED_O && !START_O)
		else $error("blocked not raised on blocked pick-up");
	chk_blocked_quiet: assert property (BLOCKED_O |-> !START_O && !TRIP_O)
		else $error("start or trip while blocked");
	chk_block_drop: assert property (tick && START_O && BLOCK_I |=> !START_O)
		else $error("start kept under blocking");
	chk_trip_after: assert property ($rose(TRIP_O) |-> $past(START_O) && $past(op_done))
		else $error("trip without elapsed operate delay");
	chk_no_tick_move: assert property (!tick |=> $stable(state_q))
		else $error("stage moved between program cycles");
	// ---------------------------------------------------------------
	// events and counters
	// ---------------------------------------------------------------
	wire [2:0] flags = {BLOCKED_O, TRIP_O, START_O};
	logic [2:0] prev_q;
	wire [2:0] evt_on = flags & ~prev_q;
	wire [2:0] evt_off = ~flags & prev_q;
	logic [31:0] cnt_q [3];
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			prev_q <= 3'h0;
			EVT_O <= '0;
		end else begin
			prev_q <= flags;
			EVT_O.code <= {evt_off, evt_on} & evmask_q;
			EVT_O.stamp <= TIME_I;
		end
	end
	// a count landing with the clear survives as one
	always_ff @(posedge CORE_CLK_I) begin
		for (int i = 0; i < 3; i++) begin
			if (RESET_I) cnt_q[i] <= 32'h0;
			else if (cnt_clr) cnt_q[i] <= {31'h0, evt_on[i]};
			else cnt_q[i] <= cnt_q[i] + {31'h0, evt_on[i]};
		end
	end
	chk_evt_masked: assert property (##1 (EVT_O.code & ~$past(evmask_q)) == 6'h0)
		else $error("masked event reported");
	chk_trip_count: assert property (evt_on[1] && !cnt_clr |=> cnt_q[1] == $past(cnt_q[1]) + 32'h1)
		else $error("trip counter did not step");
	// ---------------------------------------------------------------
	// operation log
	// ---------------------------------------------------------------
	ps_pkg::log_entry_s log_q [`LOG_DEPTH];
	logic [3:0] wp_q, lcnt_q;
	wire [1:0] log_id = evt_on[1] ? 2'h1 : (evt_on[2] ? 2'h2 : 2'h0);
	wire [3:0] wp_nx = (wp_q == 4'(`LOG_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
	// newest first: select zero is the latest record
	wire [4:0] rd_raw = 5'(wp_q) + 5'(`LOG_DEPTH - 1) - 5'(log_sel_q);
	wire [3:0] rd_idx = 4'((rd_raw >= 5'(`LOG_DEPTH)) ? rd_raw - 5'(`LOG_DEPTH) : rd_raw);
	wire ps_pkg::log_entry_s lrd = (log_sel_q < lcnt_q) ? log_q[rd_idx] : '0;
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			wp_q <= 4'h0;
			lcnt_q <= 4'h0;
		end else if (|evt_on) begin
			wp_q <= wp_nx;
			if (lcnt_q != 4'(`LOG_DEPTH)) lcnt_q <= lcnt_q + 4'h1;
		end
	end
	// record is written on an on event only; oldest slot is reused
	always_ff @(posedge CORE_CLK_I) begin
		if (|evt_on) begin
			log_q[wp_q].stamp <= TIME_I;
			log_q[wp_q].grp <= SET_GROUP_I;
			log_q[wp_q].id <= log_id;
			log_q[wp_q].mag <= MEAS_I[0];
			log_q[wp_q].ratio <= ratio_q[0];
			log_q[wp_q].remain <= remain;
		end
	end
	chk_log_wrap: assert property (|evt_on |=> wp_q == $past(wp_nx) && lcnt_q <= 4'(`LOG_DEPTH))
		else $error("log pointer out of step");
	// ---------------------------------------------------------------
	// register read
	// ---------------------------------------------------------------
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0;
		if (ch_hit && ch_idx < 2'(`N_CH)) begin
			if (fld == `F_MODE) rd_d = {28'h0, mode_q[ch_idx]};
			if (fld == `F_PICK) rd_d = pick_q[ch_idx];
			if (fld == `F_HYST) rd_d = {16'h0, hyst_q[ch_idx]};
			if (fld == `F_BLIM) rd_d = blim_q[ch_idx];
		end
		case (addr)
			`A_OPDLY: rd_d = {13'h0, opdly_q};
			`A_RELDLY: rd_d = {13'h0, reldly_q};
			`A_EVMASK: rd_d = {26'h0, evmask_q};
			`A_STATUS: rd_d = {23'h0, state_q, act_q, flags};
			`A_CNT_START: rd_d = cnt_q[0];
			`A_CNT_TRIP: rd_d = cnt_q[1];
			`A_CNT_BLK: rd_d = cnt_q[2];
			`A_RATIO0: rd_d = ratio_q[0];
			`A_RATIO1: rd_d = ratio_q[1];
			`A_RATIO2: rd_d = ratio_q[2];
			`A_REMAIN: rd_d = {13'h0, remain};
			`A_LOG_SEL: rd_d = {28'h0, log_sel_q};
			`A_LOG_CNT: rd_d = {28'h0, lcnt_q};
			`A_LOG_TIME: rd_d = lrd.stamp;
			`A_LOG_INFO: rd_d = {27'h0, lrd.grp, lrd.id};
			`A_LOG_MAG: rd_d = lrd.mag;
			`A_LOG_RATIO: rd_d = lrd.ratio;
			`A_LOG_REMAIN: rd_d = {13'h0, lrd.remain};
			default: ;
		endcase
	end
	// data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I || !REG_REQ_I.rd) REG_RDATA_O <= 32'h0;
		else REG_RDATA_O <= rd_d;
	end
endmodule : programmable_stage

// File: ps_map.svh
// offsets, field positions, reset values and timing counts of the programmable stage
`ifndef PS_MAP_SVH
`define PS_MAP_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define PROG_CYCLE_NS 5000000
`define PROG_CYCLE_MS 5
`define DELTA_WIN_MS 20
`define DELTA_TAPS (`DELTA_WIN_MS / `PROG_CYCLE_MS)
// ---------------------------------------------------------------
// scaling and limits
// ---------------------------------------------------------------
`define PCT_SCALE 64'sd10000
`define RATIO_LIM 64'sd5000000
`define LOG_DEPTH 12
`define N_CH 3
`define CH_SHIFT 4
`define FLD_MASK 8'h0f
`define EN_BIT 3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MODE_RST 4'h8
`define PICK_RST 32'h00000001
`define HYST_RST 16'h012c
`define BLIM_RST 32'h80000000
`define OPDLY_RST 19'h00008
`define RELDLY_RST 19'h0000c
`define EVMASK_RST 6'h3f
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define A_CH_LAST 8'h2f
`define F_MODE 8'h00
`define F_PICK 8'h04
`define F_HYST 8'h08
`define F_BLIM 8'h0c
`define A_OPDLY 8'h30
`define A_RELDLY 8'h34
`define A_EVMASK 8'h38
`define A_CTRL 8'h3c
`define A_STATUS 8'h40
`define A_CNT_START 8'h44
`define A_CNT_TRIP 8'h48
`define A_CNT_BLK 8'h4c
`define A_RATIO0 8'h50
`define A_RATIO1 8'h54
`define A_RATIO2 8'h58
`define A_REMAIN 8'h5c
`define A_LOG_SEL 8'h60
`define A_LOG_CNT 8'h64
`define A_LOG_TIME 8'h68
`define A_LOG_INFO 8'h6c
`define A_LOG_MAG 8'h70
`define A_LOG_RATIO 8'h74
`define A_LOG_REMAIN 8'h78
`endif

// File: ps_pkg.sv
// types shared by the programmable stage
package ps_pkg;
	// ---------------------------------------------------------------
	// modes and states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		M_OVER = 3'b000, M_OVER_ABS = 3'b001, M_UNDER = 3'b010, M_UNDER_ABS = 3'b011,
		M_DREL_DIR = 3'b100, M_DREL_ABS = 3'b101, M_DVAL_DIR = 3'b110, M_DVAL_ABS = 3'b111
	} cmp_mode_e;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_START = 3'b001, S_TRIP = 3'b010,
		S_REL_S = 3'b011, S_REL_T = 3'b100, S_BLOCKED = 3'b101
	} stage_state_e;
	typedef logic signed [63:0] wide_t;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic [5:0] code;
		logic [31:0] stamp;
	} evt_s;
	typedef struct packed {
		logic [31:0] stamp;
		logic [2:0] grp;
		logic [1:0] id;
		logic [31:0] mag;
		logic [31:0] ratio;
		logic [18:0] remain;
	} log_entry_s;
endpackage : ps_pkg

// File: meas_partner.sv
// stand-in for the measurement subsystem and blocking matrix feeding the stage
`timescale 1ns/100ps
module meas_partner (
	// clock
	input wire logic CORE_CLK_I,
	// values commanded by the bench
	input wire logic [2:0][31:0] meas_cmd_i,
	input wire logic block_cmd_i,
	// towards the stage
	output logic [2:0][31:0] meas_o,
	output logic block_o
);
	// ---------------------------------------------------------------
	// source registers
	// ---------------------------------------------------------------
	// values move only just after an edge, as a sampled source would
	always_ff @(posedge CORE_CLK_I) begin
		meas_o <= meas_cmd_i;
		block_o <= block_cmd_i;
	end
endmodule : meas_partner

// File: programmable_stage_test.sv
// self-checking bench of the programmable stage
`timescale 1ns/100ps
`include "ps_map.svh"
module programmable_stage_test;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int TICK = 10;
	localparam logic [31:0] STAMP = 32'h0000abcd;
	logic clk, rst, block_cmd, blk;
	ps_pkg::reg_req_s req;
	logic [31:0] rdata, got, last_stamp;
	logic [2:0][31:0] meas_cmd, meas;
	logic start, trip, blocked;
	logic [2:0] fl;
	assign fl = {blocked, trip, start};
	ps_pkg::evt_s evt;
	logic [5:0] seen;
	int mismatches, num_checks, cycles, n;
	// clock and event monitor
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
		if (evt.code !== 6'h00) begin
			seen = seen | evt.code;
			last_stamp = evt.stamp;
		end
	end
	meas_partner far (.CORE_CLK_I(clk), .meas_cmd_i(meas_cmd), .block_cmd_i(block_cmd), .meas_o(meas), .block_o(blk));
	programmable_stage #(.TICK_CYCLES(TICK)) dut (.CORE_CLK_I(clk), .RESET_I(rst), .REG_REQ_I(req),
		.REG_RDATA_O(rdata), .MEAS_I(meas), .BLOCK_I(blk), .SET_GROUP_I(3'h5), .TIME_I(STAMP),
		.START_O(start), .TRIP_O(trip), .BLOCKED_O(blocked), .EVT_O(evt));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_flags(input logic [2:0] e);
		num_checks++;
		if ({blocked, trip, start} !== e) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, {blocked, trip, start}, e);
		end
	endtask : chk_flags
	task automatic chk_count(input int g, input int lo, input int hi);
		num_checks++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, g, lo);
		end
	endtask : chk_count
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) req <= '0;
		#1 d = rdata;
	endtask : rd
	// wait on one output flag (0 start, 1 trip, 2 blocked), bounded
	task automatic wait_flag(input int idx, input logic v, output int k);
		k = 0;
		while (fl[idx] !== v && k < 800) begin
			@(posedge clk);
			#1 k++;
		end
	endtask : wait_flag
	task automatic cfg(input logic [31:0] mode, input logic [31:0] pick, input logic [31:0] blim);
		wr(`F_MODE, mode);
		wr(`F_PICK, pick);
		wr(`F_BLIM, blim);
	endtask : cfg
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic reset_values();
		logic [7:0] a[9] = '{`F_MODE, `F_PICK, `F_HYST, `F_BLIM, `A_OPDLY, `A_RELDLY, `A_EVMASK, 8'h7c, `A_STATUS};
		logic [31:0] e[9] = '{32'h8, 32'h1, 32'h12c, 32'h80000000, 32'h8, 32'hc, 32'h3f, 32'h0, 32'h0};
		wr(`A_STATUS, 32'hffffffff);
		for (int i = 0; i < 9; i++) begin
			rd(a[i], got);
			chk_word(got, e[i]);
		end
	endtask : reset_values
	// negative level, over mode: start, trip after operate delay, release
	task automatic over_cycle();
		wr(`A_OPDLY, 32'h3);
		wr(`A_RELDLY, 32'h2);
		cfg(32'h8, -32'sd50, 32'h80000000);
		seen = 6'h00;
		meas_cmd[0] <= -32'sd20;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		wait_flag(1, 1'b1, n);
		chk_count(n, 3 * TICK - 1, 3 * TICK + 1);
		meas_cmd[0] <= -32'sd80;
		wait_flag(0, 1'b0, n);
		chk_count(n, TICK, 3 * TICK + 2);
		chk_flags(3'b000);
		repeat (3) @(posedge clk);
		chk_word({26'h0, seen}, 32'h1b);
		chk_word(last_stamp, STAMP);
		rd(`A_CNT_TRIP, got);
		chk_word(got, 32'h1);
		rd(`A_LOG_CNT, got);
		chk_word(got, 32'h2);
		rd(`A_LOG_INFO, got);
		chk_word(got, 32'h15);
		rd(`A_LOG_TIME, got);
		chk_word(got, STAMP);
		rd(`A_LOG_MAG, got);
		chk_word(got, -32'sd20);
		rd(`A_LOG_REMAIN, got);
		chk_word(got, 32'h0);
	endtask : over_cycle
	// under mode below the blocking limit stays quiet, above it picks up
	task automatic under_limit();
		wr(`A_OPDLY, 32'h40);
		wr(`A_EVMASK, 32'h07);
		cfg(32'h2, 32'd100, 32'd50);
		meas_cmd[0] <= 32'd20;
		wr(`F_MODE, 32'ha);
		seen = 6'h00;
		repeat (4 * TICK) @(posedge clk);
		chk_flags(3'b000);
		meas_cmd[0] <= 32'd70;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		meas_cmd[0] <= 32'd200;
		wait_flag(0, 1'b0, n);
		chk_count(n, 1, 4 * TICK);
		repeat (3) @(posedge clk);
		chk_word({26'h0, seen}, 32'h01);
		wr(`A_EVMASK, 32'h3f);
	endtask : under_limit
	// absolute over mode with blocking before and during start
	task automatic blocking();
		meas_cmd[0] <= 32'd0;
		cfg(32'h9, 32'd100, 32'h80000000);
		block_cmd <= 1'b1;
		meas_cmd[0] <= -32'sd150;
		wait_flag(2, 1'b1, n);
		repeat (2 * TICK) @(posedge clk);
		chk_flags(3'b100);
		rd(`A_RATIO0, got);
		chk_word(got, 32'hffffffff);
		block_cmd <= 1'b0;
		meas_cmd[0] <= 32'd0;
		wait_flag(2, 1'b0, n);
		meas_cmd[0] <= -32'sd150;
		wait_flag(0, 1'b1, n);
		chk_flags(3'b001);
		block_cmd <= 1'b1;
		wait_flag(2, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		chk_flags(3'b100);
		rd(`A_CNT_BLK, got);
		chk_word(got, 32'h2);
		wr(`A_CTRL, 32'h1);
		rd(`A_CNT_START, got);
		chk_word(got, 32'h0);
		block_cmd <= 1'b0;
		meas_cmd[0] <= 32'd0;
		wait_flag(2, 1'b0, n);
		// let the 20 ms history forget the blocked step
		repeat (5 * TICK) @(posedge clk);
	endtask : blocking
	// absolute value change: a drop larger than the level picks up
	task automatic delta_value();
		cfg(32'hf, 32'd100, 32'h80000000);
		repeat (6 * TICK) @(posedge clk);
		chk_flags(3'b000);
		meas_cmd[0] <= -32'sd150;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		wait_flag(0, 1'b0, n);
		chk_count(n, 2 * TICK, 8 * TICK);
	endtask : delta_value
	// under abs, directional value change, relative changes in both kinds
	task automatic more_modes();
		cfg(32'hb, 32'd100, 32'd50);
		meas_cmd[0] <= -32'sd70;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		cfg(32'h6, -32'sd100, 32'h80000000);
		repeat (5 * TICK) @(posedge clk);
		wr(`F_MODE, 32'he);
		meas_cmd[0] <= 32'd60;
		repeat (6 * TICK) @(posedge clk);
		chk_flags(3'b000);
		meas_cmd[0] <= -32'sd70;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		wait_flag(0, 1'b0, n);
		chk_count(n, 2 * TICK, 8 * TICK);
		cfg(32'hc, 32'd1000, 32'h80000000);
		meas_cmd[0] <= -32'sd80;
		repeat (6 * TICK) @(posedge clk);
		chk_flags(3'b000);
		meas_cmd[0] <= -32'sd60;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
		wait_flag(0, 1'b0, n);
		wr(`F_MODE, 32'hd);
		meas_cmd[0] <= -32'sd90;
		wait_flag(0, 1'b1, n);
		chk_count(n, 1, TICK + 2);
	endtask : more_modes
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		req = '0;
		meas_cmd = '0;
		block_cmd = 1'b0;
		seen = 6'h00;
		last_stamp = 32'h0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reset_values();
		meas_cmd[0] <= -32'sd80;
		over_cycle();
		under_limit();
		blocking();
		delta_value();
		more_modes();
		conclude();
	end
endmodule : programmable_stage_test
